// *** ppr_divider.sv ***
// unsigned restoring divider, one quotient bit per clock
module ppr_divider (
	input wire logic pclk, // control clock
	input wire logic presetn, // asynchronous reset, active low
	input wire logic start, // one-cycle request, ignored while busy
	input wire logic [31:0] numerator, // dividend
	input wire logic [23:0] denominator, // divisor, caller keeps it non-zero
	output logic done, // one-cycle pulse, quotient valid
	output logic [31:0] quotient // result
);

	logic [23:0] rem_reg;
	logic [23:0] den_reg;
	logic [31:0] quo_reg;
	logic [5:0] cnt_reg;
	logic busy_reg;
	logic done_reg;
	logic [24:0] shifted;

	assign shifted = {rem_reg, quo_reg[31]};
	assign done = done_reg;
	assign quotient = quo_reg;

	// shift-subtract loop; 32 steps then a done pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_reg <= 24'h000000;
			den_reg <= 24'h000000;
			quo_reg <= 32'h00000000;
			cnt_reg <= 6'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (start && !busy_reg) begin
				rem_reg <= 24'h000000;
				den_reg <= denominator;
				quo_reg <= numerator;
				cnt_reg <= 6'h20;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (shifted >= {1'b0, den_reg}) begin
					rem_reg <= 24'(shifted - {1'b0, den_reg});
					quo_reg <= {quo_reg[30:0], 1'b1};
				end else begin
					rem_reg <= shifted[23:0];
					quo_reg <= {quo_reg[30:0], 1'b0};
				end
				cnt_reg <= cnt_reg - 6'h01;
				if (cnt_reg == 6'h01) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end

endmodule

// *** ppr_pkg.sv ***
package ppr_pkg;

	// register byte offsets on the apb slave
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] SOURCE_OFF = 8'h04;
	localparam logic [7:0] DIG_TARGET_OFF = 8'h08;
	localparam logic [7:0] FULL_SCALE_OFF = 8'h0C;
	localparam logic [7:0] KP_OFF = 8'h10;
	localparam logic [7:0] TI_OFF = 8'h14;
	localparam logic [7:0] TD_OFF = 8'h18;
	localparam logic [7:0] REV_CUT_OFF = 8'h1C;
	localparam logic [7:0] DEV_LIMIT_OFF = 8'h20;
	localparam logic [7:0] DIFF_LIMIT_OFF = 8'h24;
	localparam logic [7:0] CHANGE_TIME_OFF = 8'h28;
	localparam logic [7:0] FB_FILTER_OFF = 8'h2C;
	localparam logic [7:0] OUT_FILTER_OFF = 8'h30;
	localparam logic [7:0] MAX_FREQ_OFF = 8'h34;
	localparam logic [7:0] TARGET_STAT_OFF = 8'h38;
	localparam logic [7:0] FEEDBACK_STAT_OFF = 8'h3C;
	localparam logic [7:0] TARGET_DISP_OFF = 8'h40;
	localparam logic [7:0] FEEDBACK_DISP_OFF = 8'h44;
	localparam logic [7:0] FREQ_CMD_OFF = 8'h48;

	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_DIR_BIT = 1;
	localparam int SRC_TARGET_LSB = 0;
	localparam int SRC_FEEDBACK_LSB = 4;

	// reset values and limits (units: 0.1 %, 0.01 %, 0.1, 0.01 s, 0.001 s, 0.01 Hz)
	localparam logic [15:0] DIG_TARGET_RST = 16'h01F4;
	localparam logic [15:0] DIG_TARGET_MAX = 16'h03E8;
	localparam logic [15:0] FULL_SCALE_RST = 16'h03E8;
	localparam logic [15:0] KP_RST = 16'h00C8;
	localparam logic [15:0] KP_MAX = 16'h03E8;
	localparam logic [15:0] TI_RST = 16'h00C8;
	localparam logic [15:0] TI_MIN = 16'h0001;
	localparam logic [15:0] TI_MAX = 16'h03E8;
	localparam logic [15:0] TD_RST = 16'h0000;
	localparam logic [15:0] TD_MAX = 16'h2710;
	localparam logic [15:0] REV_CUT_RST = 16'h00C8;
	localparam logic [15:0] DEV_LIMIT_RST = 16'h0000;
	localparam logic [15:0] DEV_LIMIT_MAX = 16'h03E8;
	localparam logic [15:0] DIFF_LIMIT_RST = 16'h000A;
	localparam logic [15:0] DIFF_LIMIT_MAX = 16'h2710;
	localparam logic [15:0] CHANGE_TIME_MAX = 16'hFDE8;
	localparam logic [15:0] FILTER_TIME_MAX = 16'h1770;
	localparam logic [15:0] MAX_FREQ_RST = 16'h1388;

	// percent scale: 100.00 % in units of 0.01 %
	localparam logic [15:0] PCT_FULL = 16'h2710;
	localparam int FRAC_BITS = 8;

	// control beat timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int BEAT_TIME_NS = 2000000;
	localparam int BEAT_CYCLES = BEAT_TIME_NS / CLK_PERIOD_NS;
	localparam int BEAT_TIME_US = BEAT_TIME_NS / 1000;
	localparam int BEATS_PER_CS = 10000 / BEAT_TIME_US;
	localparam int BEAT_TIME_MS = BEAT_TIME_US / 1000;

	typedef enum logic [3:0] {
		SEL_DIGITAL, SEL_AIN_ONE, SEL_AIN_TWO, SEL_RESERVED3, SEL_PULSE, SEL_COMM,
		SEL_MULTI, SEL_SUM, SEL_MAXIMUM, SEL_MINIMUM
	} ppr_sel_type;

endpackage

// *** ppr_regulator.sv ***
// Behaviour
// [R1] target source: 0 stored, 1 analog one, 2 analog two, 4 pulse, 5 comm, 6 multi-step
// [R2] stored digital target held within 0..100.0 %, fifty percent after reset
// [R3] feedback source 0,1,3 difference,4,5,6 sum,7 max,8 min; 2 reserved
// [R4] feedback is a relative percentage limited to 0..100 %; clamped only when feedback filter time is zero
// [R5] direction 0: feedback below target raises frequency command
// [R6] direction 1: feedback below target lowers frequency command
// [R7] reversal input terminal inverts the programmed direction
// [R8] display value: 100 % maps linearly to programmable full scale, default 1000
// [R9] gain 100.0 with full deviation adjusts command by maximum frequency
// [R10] full deviation integrates to maximum frequency in integral time
// [R11] full-scale change within derivative time gives maximum frequency
// [R12] reverse demand magnitude clamped to reverse cutoff, default 2.00 Hz
// [R13] deviation below limit holds the output unchanged
// [R14] derivative contribution clamped to programmable band, default 0.10 %
// [R15] target ramps linearly; full change takes the programmed change time
// [R16] feedback smoothed by filter with programmable time, zero bypasses
// [R17] output frequency smoothed by filter with programmable time, zero bypasses
// [R18] command continuously adjusted to drive feedback toward target
// [R19] computation and output update once per two millisecond beat
// [R20] filters are first-order low-pass, time constant as programmed
// [R21] summed output saturated between minus reverse cutoff and maximum frequency
module ppr_regulator #(
	parameter int unsigned BEAT_CYCLES = ppr_pkg::BEAT_CYCLES
) (
	input wire logic pclk, // control clock, 20 MHz
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready, always high
	output logic pslverr, // apb error on unmapped address
	input wire logic [15:0] analog_input_one, // 0.01 % units
	input wire logic [15:0] analog_input_two_current, // 0.01 % units
	input wire logic [15:0] pulse_input_terminal, // pulse input as 0.01 %
	input wire logic [15:0] comm_target, // communication target, 0.01 %
	input wire logic [15:0] comm_feedback, // communication feedback, 0.01 %
	input wire logic [15:0] multi_step_target, // multi-step target, 0.01 %
	input wire logic direction_reverse, // reversal terminal level
	output logic signed [17:0] freq_cmd, // frequency command, 0.01 Hz
	output logic beat_done // pulse when a beat's computation ends
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_RAMP, ST_FBF, ST_CALC, ST_INTG, ST_OUTF
	} ppr_state_type;

	localparam int FB = ppr_pkg::FRAC_BITS;

	logic run_reg, dir_reg;
	logic [3:0] tsel_reg, fsel_reg;
	logic [15:0] dig_target_reg, full_scale_reg, kp_reg, ti_reg, td_reg, rev_cut_reg;
	logic [15:0] dev_limit_reg, diff_limit_reg, change_time_reg, fb_filt_reg;
	logic [15:0] out_filt_time_reg, max_freq_reg;
	logic [31:0] prdata_reg;
	logic [31:0] beat_cnt_reg;
	logic beat_tick;
	ppr_state_type state_reg;
	logic [23:0] ramp_reg, fbf_reg;
	logic signed [17:0] err_reg, err_prev_reg;
	logic signed [31:0] prop_reg, deriv_reg, integ_reg, outf_reg;
	logic signed [17:0] freq_reg;
	logic done_reg, div_pend_reg;
	logic [15:0] target_raw, feedback_raw, target_pct, feedback_pct;
	logic signed [17:0] err_now;
	logic signed [31:0] div_diff, div_signed, ftgt;
	logic [23:0] div_den;
	logic div_needed, div_start, div_done;
	logic [31:0] div_quo;
	logic wr_en, rd_setup, addr_hit;

	// clamp a written value to an upper bound
	function automatic logic [15:0] clamp_hi(input logic [31:0] v, input logic [15:0] hi);
		clamp_hi = (v > {16'h0000, hi}) ? hi : v[15:0];
	endfunction

	// map a relative percentage to the display full scale
	function automatic logic [31:0] to_display(input logic [15:0] pct, input logic [15:0] fs);
		to_display = ({16'h0000, pct} * {16'h0000, fs}) / 32'(ppr_pkg::PCT_FULL);
	endfunction

	// beats of a time setting: 0.01 s units times beats per 0.01 s
	function automatic logic [23:0] beats_of(input logic [15:0] t);
		beats_of = 24'(t) * 24'(ppr_pkg::BEATS_PER_CS);
	endfunction

	// apb decode: setup phase latches read data, write lands in access phase
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && addr_hit;
	assign rd_setup = psel && !penable;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata = prdata_reg;
	always_comb begin
		unique case (paddr)
			ppr_pkg::CTRL_OFF, ppr_pkg::SOURCE_OFF, ppr_pkg::DIG_TARGET_OFF,
			ppr_pkg::FULL_SCALE_OFF, ppr_pkg::KP_OFF, ppr_pkg::TI_OFF, ppr_pkg::TD_OFF,
			ppr_pkg::REV_CUT_OFF, ppr_pkg::DEV_LIMIT_OFF, ppr_pkg::DIFF_LIMIT_OFF,
			ppr_pkg::CHANGE_TIME_OFF, ppr_pkg::FB_FILTER_OFF, ppr_pkg::OUT_FILTER_OFF,
			ppr_pkg::MAX_FREQ_OFF, ppr_pkg::TARGET_STAT_OFF, ppr_pkg::FEEDBACK_STAT_OFF,
			ppr_pkg::TARGET_DISP_OFF, ppr_pkg::FEEDBACK_DISP_OFF,
			ppr_pkg::FREQ_CMD_OFF: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// settings registers; out-of-range writes are clamped, not rejected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
			dir_reg <= 1'b0;
			tsel_reg <= 4'h0;
			fsel_reg <= 4'h0;
			dig_target_reg <= ppr_pkg::DIG_TARGET_RST;
			full_scale_reg <= ppr_pkg::FULL_SCALE_RST;
			kp_reg <= ppr_pkg::KP_RST;
			ti_reg <= ppr_pkg::TI_RST;
			td_reg <= ppr_pkg::TD_RST;
			rev_cut_reg <= ppr_pkg::REV_CUT_RST;
			dev_limit_reg <= ppr_pkg::DEV_LIMIT_RST;
			diff_limit_reg <= ppr_pkg::DIFF_LIMIT_RST;
			change_time_reg <= 16'h0000;
			fb_filt_reg <= 16'h0000;
			out_filt_time_reg <= 16'h0000;
			max_freq_reg <= ppr_pkg::MAX_FREQ_RST;
		end else if (wr_en) begin
			unique case (paddr)
				ppr_pkg::CTRL_OFF: begin
					run_reg <= pwdata[ppr_pkg::CTRL_RUN_BIT];
					dir_reg <= pwdata[ppr_pkg::CTRL_DIR_BIT]; // [R5] [R6]
				end
				ppr_pkg::SOURCE_OFF: begin
					tsel_reg <= pwdata[ppr_pkg::SRC_TARGET_LSB +: 4];
					fsel_reg <= pwdata[ppr_pkg::SRC_FEEDBACK_LSB +: 4];
				end
				ppr_pkg::DIG_TARGET_OFF: dig_target_reg <= clamp_hi(pwdata, ppr_pkg::DIG_TARGET_MAX); // [R2]
				ppr_pkg::FULL_SCALE_OFF: full_scale_reg <= pwdata[15:0];
				ppr_pkg::KP_OFF: kp_reg <= clamp_hi(pwdata, ppr_pkg::KP_MAX);
				ppr_pkg::TI_OFF: ti_reg <= (pwdata[15:0] < ppr_pkg::TI_MIN) ? ppr_pkg::TI_MIN :
					clamp_hi(pwdata, ppr_pkg::TI_MAX);
				ppr_pkg::TD_OFF: td_reg <= clamp_hi(pwdata, ppr_pkg::TD_MAX);
				ppr_pkg::REV_CUT_OFF: rev_cut_reg <= clamp_hi(pwdata, max_freq_reg);
				ppr_pkg::DEV_LIMIT_OFF: dev_limit_reg <= clamp_hi(pwdata, ppr_pkg::DEV_LIMIT_MAX);
				ppr_pkg::DIFF_LIMIT_OFF: diff_limit_reg <= clamp_hi(pwdata, ppr_pkg::DIFF_LIMIT_MAX);
				ppr_pkg::CHANGE_TIME_OFF: change_time_reg <= clamp_hi(pwdata, ppr_pkg::CHANGE_TIME_MAX);
				ppr_pkg::FB_FILTER_OFF: fb_filt_reg <= clamp_hi(pwdata, ppr_pkg::FILTER_TIME_MAX);
				ppr_pkg::OUT_FILTER_OFF: out_filt_time_reg <= clamp_hi(pwdata, ppr_pkg::FILTER_TIME_MAX);
				ppr_pkg::MAX_FREQ_OFF: max_freq_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// read data captured in the setup phase so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (rd_setup) begin
			unique case (paddr)
				ppr_pkg::CTRL_OFF: prdata_reg <= {30'h00000000, dir_reg, run_reg};
				ppr_pkg::SOURCE_OFF: prdata_reg <= {24'h000000, fsel_reg, tsel_reg};
				ppr_pkg::DIG_TARGET_OFF: prdata_reg <= {16'h0000, dig_target_reg};
				ppr_pkg::FULL_SCALE_OFF: prdata_reg <= {16'h0000, full_scale_reg};
				ppr_pkg::KP_OFF: prdata_reg <= {16'h0000, kp_reg};
				ppr_pkg::TI_OFF: prdata_reg <= {16'h0000, ti_reg};
				ppr_pkg::TD_OFF: prdata_reg <= {16'h0000, td_reg};
				ppr_pkg::REV_CUT_OFF: prdata_reg <= {16'h0000, rev_cut_reg};
				ppr_pkg::DEV_LIMIT_OFF: prdata_reg <= {16'h0000, dev_limit_reg};
				ppr_pkg::DIFF_LIMIT_OFF: prdata_reg <= {16'h0000, diff_limit_reg};
				ppr_pkg::CHANGE_TIME_OFF: prdata_reg <= {16'h0000, change_time_reg};
				ppr_pkg::FB_FILTER_OFF: prdata_reg <= {16'h0000, fb_filt_reg};
				ppr_pkg::OUT_FILTER_OFF: prdata_reg <= {16'h0000, out_filt_time_reg};
				ppr_pkg::MAX_FREQ_OFF: prdata_reg <= {16'h0000, max_freq_reg};
				ppr_pkg::TARGET_STAT_OFF: prdata_reg <= {16'h0000, target_pct};
				ppr_pkg::FEEDBACK_STAT_OFF: prdata_reg <= {16'h0000, feedback_pct};
				ppr_pkg::TARGET_DISP_OFF: prdata_reg <= to_display(target_pct, full_scale_reg); // [R8]
				ppr_pkg::FEEDBACK_DISP_OFF: prdata_reg <= to_display(feedback_pct, full_scale_reg); // [R8]
				ppr_pkg::FREQ_CMD_OFF: prdata_reg <= 32'(freq_reg);
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end

	// source selection; reserved codes give zero, combined feedback saturates
	always_comb begin
		unique case (tsel_reg)
			ppr_pkg::SEL_DIGITAL: target_raw = 16'(dig_target_reg * 16'h000A); // [R1]
			ppr_pkg::SEL_AIN_ONE: target_raw = analog_input_one; // [R1]
			ppr_pkg::SEL_AIN_TWO: target_raw = analog_input_two_current; // [R1]
			ppr_pkg::SEL_PULSE: target_raw = pulse_input_terminal; // [R1]
			ppr_pkg::SEL_COMM: target_raw = comm_target; // [R1]
			ppr_pkg::SEL_MULTI: target_raw = multi_step_target; // [R1]
			default: target_raw = 16'h0000;
		endcase
		unique case (fsel_reg)
			4'h0: feedback_raw = analog_input_one; // [R3]
			4'h1: feedback_raw = analog_input_two_current; // [R3]
			4'h3: feedback_raw = (analog_input_one > analog_input_two_current) ?
				16'(analog_input_one - analog_input_two_current) : 16'h0000; // [R3]
			4'h4: feedback_raw = pulse_input_terminal; // [R3]
			4'h5: feedback_raw = comm_feedback; // [R3]
			4'h6: feedback_raw = clamp_hi(32'(analog_input_one) + 32'(analog_input_two_current),
				ppr_pkg::PCT_FULL); // [R3]
			4'h7: feedback_raw = (analog_input_one > analog_input_two_current) ?
				analog_input_one : analog_input_two_current; // [R3]
			4'h8: feedback_raw = (analog_input_one < analog_input_two_current) ?
				analog_input_one : analog_input_two_current; // [R3]
			default: feedback_raw = 16'h0000;
		endcase
	end

	// effective target and filtered feedback in whole 0.01 % steps
	assign target_pct = ramp_reg[FB +: 16];
	assign feedback_pct = fbf_reg[FB +: 16];

	// beat timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			beat_cnt_reg <= 32'h00000000;
		end else if (beat_cnt_reg == 32'(BEAT_CYCLES - 1)) begin
			beat_cnt_reg <= 32'h00000000;
		end else begin
			beat_cnt_reg <= beat_cnt_reg + 32'h00000001;
		end
	end
	assign beat_tick = (beat_cnt_reg == 32'(BEAT_CYCLES - 1)); // [R19]

	// deviation sign follows direction setting and reversal terminal
	assign err_now = (dir_reg ^ direction_reverse) ?
		18'(signed'({2'b00, feedback_pct}) - signed'({2'b00, clamp_hi(32'(target_pct),
		ppr_pkg::PCT_FULL)})) :
		18'(signed'({2'b00, clamp_hi(32'(target_pct), ppr_pkg::PCT_FULL)}) -
		signed'({2'b00, feedback_pct})); // [R5] [R6] [R7] [R18]

	// sum of terms scaled to frequency, then saturated into the allowed band
	always_comb begin
		logic signed [47:0] u;
		u = 48'(prop_reg + (integ_reg >>> FB) + deriv_reg) * 48'(signed'({1'b0, max_freq_reg}));
		u = u / 48'(signed'({1'b0, ppr_pkg::PCT_FULL})); // [R9]
		if (u > 48'(signed'({1'b0, max_freq_reg}))) begin
			ftgt = 32'(signed'({1'b0, max_freq_reg})); // [R21]
		end else if (u < -48'(signed'({1'b0, rev_cut_reg}))) begin
			ftgt = -32'(signed'({1'b0, rev_cut_reg})); // [R12] [R21]
		end else begin
			ftgt = 32'(u);
		end
	end

	// divider operands per state; magnitude divided, sign restored after
	always_comb begin
		div_diff = 32'sh00000000;
		div_den = 24'h000001;
		div_needed = 1'b0;
		unique case (state_reg)
			ST_RAMP: begin
				div_diff = 32'(ppr_pkg::PCT_FULL) <<< FB;
				div_den = beats_of(change_time_reg); // [R15]
				div_needed = (change_time_reg != 16'h0000);
			end
			ST_FBF: begin
				div_diff = 32'({8'h00, feedback_raw, 8'h00}) - 32'({8'h00, fbf_reg});
				div_den = beats_of(fb_filt_reg); // [R16] [R20]
				div_needed = (fb_filt_reg != 16'h0000);
			end
			ST_INTG: begin
				div_diff = 32'(err_reg) <<< FB;
				div_den = beats_of(ti_reg); // [R10]
				div_needed = 1'b1;
			end
			ST_OUTF: begin
				div_diff = (ftgt <<< FB) - outf_reg;
				div_den = beats_of(out_filt_time_reg); // [R17] [R20]
				div_needed = (out_filt_time_reg != 16'h0000);
			end
			default: ;
		endcase
	end
	assign div_start = div_needed && !div_pend_reg && !div_done;
	assign div_signed = div_diff[31] ? -signed'(div_quo) : signed'(div_quo);

	ppr_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(div_start),
		.numerator(div_diff[31] ? 32'(-div_diff) : div_diff),
		.denominator(div_den),
		.done(div_done),
		.quotient(div_quo)
	);

	// per-beat sequence: ramp, feedback filter, terms, integral, output filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			div_pend_reg <= 1'b0;
			ramp_reg <= 24'h000000;
			fbf_reg <= 24'h000000;
			err_reg <= 18'sh00000;
			err_prev_reg <= 18'sh00000;
			prop_reg <= 32'sh00000000;
			deriv_reg <= 32'sh00000000;
			integ_reg <= 32'sh00000000;
			outf_reg <= 32'sh00000000;
			freq_reg <= 18'sh00000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (div_start) begin
				div_pend_reg <= 1'b1;
			end else if (div_done) begin
				div_pend_reg <= 1'b0;
			end
			unique case (state_reg)
				ST_IDLE: if (beat_tick) begin
					state_reg <= ST_RAMP; // [R19]
				end
				ST_RAMP: if (!div_needed) begin
					ramp_reg <= {target_raw, 8'h00};
					state_reg <= ST_FBF;
				end else if (div_done) begin
					if (ramp_reg < {target_raw, 8'h00}) begin
						ramp_reg <= ({target_raw, 8'h00} - ramp_reg > div_quo[23:0]) ?
							24'(ramp_reg + div_quo[23:0]) : {target_raw, 8'h00}; // [R15]
					end else begin
						ramp_reg <= (ramp_reg - {target_raw, 8'h00} > div_quo[23:0]) ?
							24'(ramp_reg - div_quo[23:0]) : {target_raw, 8'h00}; // [R15]
					end
					state_reg <= ST_FBF;
				end
				ST_FBF: if (!div_needed) begin
					fbf_reg <= {clamp_hi(32'(feedback_raw), ppr_pkg::PCT_FULL), 8'h00}; // [R4]
					state_reg <= ST_CALC;
				end else if (div_done) begin
					fbf_reg <= 24'(32'({8'h00, fbf_reg}) + div_signed); // [R16] [R20]
					state_reg <= ST_CALC;
				end
				ST_CALC: begin
					err_reg <= err_now;
					err_prev_reg <= err_now;
					prop_reg <= (32'(err_now) * 32'(signed'({1'b0, kp_reg}))) /
						32'(signed'({1'b0, ppr_pkg::KP_MAX})); // [R9]
					if (32'(err_now - err_prev_reg) * 32'(signed'({1'b0, td_reg})) /
						32'(ppr_pkg::BEAT_TIME_MS) > 32'(signed'({1'b0, diff_limit_reg}))) begin
						deriv_reg <= 32'(signed'({1'b0, diff_limit_reg})); // [R14]
					end else if (32'(err_now - err_prev_reg) * 32'(signed'({1'b0, td_reg})) /
						32'(ppr_pkg::BEAT_TIME_MS) < -32'(signed'({1'b0, diff_limit_reg}))) begin
						deriv_reg <= -32'(signed'({1'b0, diff_limit_reg})); // [R14]
					end else begin
						deriv_reg <= 32'(err_now - err_prev_reg) * 32'(signed'({1'b0, td_reg})) /
							32'(ppr_pkg::BEAT_TIME_MS); // [R11]
					end
					if (!run_reg) begin
						// stopped: integrator and command cleared so restart is bumpless from zero
						integ_reg <= 32'sh00000000;
						outf_reg <= 32'sh00000000;
						freq_reg <= 18'sh00000;
						state_reg <= ST_IDLE;
						done_reg <= 1'b1;
					end else if ((err_now < 0 ? -err_now : err_now) <
						18'(signed'({2'b00, dev_limit_reg}) * 18'sh0000A)) begin
						state_reg <= ST_IDLE; // [R13]
						done_reg <= 1'b1;
					end else begin
						state_reg <= ST_INTG;
					end
				end
				ST_INTG: if (div_done) begin
					// integrator bounded to full scale so it cannot wind up without limit
					// bounds kept signed: an unsigned bound would turn the compare unsigned
					if (integ_reg + div_signed > signed'(32'(ppr_pkg::PCT_FULL) <<< FB)) begin
						integ_reg <= 32'(ppr_pkg::PCT_FULL) <<< FB;
					end else if (integ_reg + div_signed < -signed'(32'(ppr_pkg::PCT_FULL) <<< FB)) begin
						integ_reg <= -(32'(ppr_pkg::PCT_FULL) <<< FB);
					end else begin
						integ_reg <= integ_reg + div_signed; // [R10]
					end
					state_reg <= ST_OUTF;
				end
				ST_OUTF: if (!div_needed) begin
					outf_reg <= ftgt <<< FB;
					freq_reg <= 18'(ftgt); // [R18] [R21]
					state_reg <= ST_IDLE;
					done_reg <= 1'b1;
				end else if (div_done) begin
					outf_reg <= outf_reg + div_signed; // [R17]
					freq_reg <= 18'((outf_reg + div_signed) >>> FB);
					state_reg <= ST_IDLE;
					done_reg <= 1'b1;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign freq_cmd = freq_reg;
	assign beat_done = done_reg;

endmodule

// *** ppr_regulator_sva.sv ***
module ppr_regulator_sva #(
	parameter int unsigned BEAT_CYCLES = 200
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // write
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic signed [17:0] freq_cmd, // command
	input wire logic beat_done // beat end
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run_q;
	int unsigned gap;
	// shadow of the run bit, so idle beats can be judged from the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_q <= 1'b0;
		else if (psel && penable && pwrite && paddr == 8'h00)
			run_q <= pwdata[0];
	end
	// cycles since the last beat end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap <= 0;
		else
			gap <= beat_done ? 0 : gap + 1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_high_a: assert property (pready) else $error("ready low");
	unmapped_err_a: assert property (psel && penable && paddr > 8'h48 |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (psel && penable && paddr <= 8'h48 && paddr[1:0] == 0 |-> !pslverr)
		else $error("mapped access refused");
	beat_pulse_a: assert property (beat_done |=> !beat_done [*8]) else $error("beat too soon");
	beat_gap_a: assert property (gap <= 2 * BEAT_CYCLES) else $error("beat missing");
	cmd_hold_a: assert property (!beat_done |-> $stable(freq_cmd)) else $error("cmd moved");
	cmd_range_a: assert property (freq_cmd >= -18'sd200 && freq_cmd <= 18'sd5000)
		else $error("cmd out of range");
	idle_zero_a: assert property (beat_done && !run_q |-> freq_cmd == 0) else $error("idle cmd");
endmodule
bind ppr_regulator ppr_regulator_sva #(.BEAT_CYCLES(BEAT_CYCLES)) u_sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.freq_cmd(freq_cmd), .beat_done(beat_done));

// *** ppr_sources.sv ***
// far side: steady levels, all different, so a wrong select reads back wrong
module ppr_sources (
	output logic [15:0] a1, // analog one
	output logic [15:0] a2, // analog two
	output logic [15:0] pl, // pulse
	output logic [15:0] ct, // comm target
	output logic [15:0] cf, // comm feedback
	output logic [15:0] ms // multi-step
);
	timeunit 1ns;
	timeprecision 1ps;
	// levels in 0.01 % units
	assign a1 = 16'h0BB8;
	assign a2 = 16'h1B58;
	assign pl = 16'h04D2;
	assign ct = 16'h10E1;
	assign cf = 16'h09C4;
	assign ms = 16'h1A0A;
endmodule

// *** tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, beat_done;
	logic direction_reverse = 1'b0;
	logic [15:0] a1, a2, pl, ct, cf, ms;
	logic signed [17:0] freq_cmd;
	int errors = 0;
	int check_count = 0;
	// 20 MHz clock
	always #25 pclk = ~pclk;
	ppr_sources src (.a1(a1), .a2(a2), .pl(pl), .ct(ct), .cf(cf), .ms(ms));
	ppr_regulator #(.BEAT_CYCLES(200)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .analog_input_one(a1), .analog_input_two_current(a2),
		.pulse_input_terminal(pl), .comm_target(ct), .comm_feedback(cf), .multi_step_target(ms),
		.direction_reverse(direction_reverse), .freq_cmd(freq_cmd), .beat_done(beat_done));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic beats(input int k);
		while (k > 0) begin
			@(posedge pclk);
			#1;
			if (beat_done === 1'b1)
				k--;
		end
	endtask
	task automatic t_idle;
		beats(1);
		chk(32'(freq_cmd), 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h000001F4);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h000003E8);
		apb(1'b0, 8'h50, 32'h0);
		chk(rd, 32'h00000000);
		apb(1'b1, 8'h08, 32'h000007D0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h000003E8);
		apb(1'b1, 8'h08, 32'h000001F4);
		$display("idle and limits done");
	endtask
	task automatic t_sources;
		logic [15:0] te[7];
		logic [15:0] fe[9];
		te = '{16'h1388, 16'h0BB8, 16'h1B58, 16'h0, 16'h04D2, 16'h10E1, 16'h1A0A};
		fe = '{16'h0BB8, 16'h1B58, 16'h0, 16'h0, 16'h04D2, 16'h09C4, 16'h2710, 16'h1B58, 16'h0BB8};
		apb(1'b1, 8'h00, 32'h1);
		// every code, target cycling through its seven
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, 8'h04, {24'h0, 4'(i), 4'(i % 7)});
			beats(2);
			apb(1'b0, 8'h38, 32'h0);
			chk(rd, {16'h0, te[i % 7]});
			apb(1'b0, 8'h3C, 32'h0);
			chk(rd, {16'h0, fe[i]});
		end
		$display("sources done");
	endtask
	task automatic t_dir;
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, 8'h0C, 32'h000007D0);
		beats(3);
		apb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h00000578);
		chk(32'(freq_cmd > 0), 32'h1);
		apb(1'b1, 8'h00, 32'h3);
		beats(4);
		chk(32'(freq_cmd), 32'hFFFFFF38);
		@(posedge pclk);
		direction_reverse <= 1'b1;
		beats(4);
		chk(32'(freq_cmd > 0), 32'h1);
		apb(1'b1, 8'h20, 32'h000003E8);
		beats(1);
		rd = 32'(freq_cmd);
		beats(3);
		chk(32'(freq_cmd), rd);
		$display("direction and dead band done");
	endtask
	// ramp of 0.02 s is ten beats, so 10.00 % per beat; feedback filter of 0.01 s
	task automatic t_ramp;
		logic [31:0] mark;
		apb(1'b1, 8'h28, 32'h2);
		apb(1'b1, 8'h2C, 32'h1);
		apb(1'b1, 8'h04, 32'h41);
		beats(2);
		apb(1'b0, 8'h38, 32'h0);
		mark = rd;
		apb(1'b0, 8'h3C, 32'h0);
		chk(32'(rd > 32'h000004D2 && rd < 32'h00000BB8), 32'h1);
		beats(1);
		apb(1'b0, 8'h38, 32'h0);
		chk(rd, mark - 32'h000003E8);
		$display("ramp and filter done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_idle();
		t_sources();
		t_dir();
		t_ramp();
		final_report();
	end
	// watchdog: about 40 beats are needed, allow over ten times that
	initial begin
		#5000000;
		errors++;
		final_report();
	end
endmodule
